// ==== include/nwb_defines.svh ====
`ifndef NWB_DEFINES_SVH
`define NWB_DEFINES_SVH

// Register byte offsets on the AXI4-Lite port.
`define NWB_CTRL_OFS 32'h0000_0000
`define NWB_STAT_OFS 32'h0000_0004

// Control register fields and reset value.
`define NWB_CTRL_INTERLEAVE_BIT 0
`define NWB_CTRL_INTERLEAVE_RST 1'h1

// Status register field positions.
`define NWB_STAT_SLEEP_BIT 0
`define NWB_STAT_STATE_LSB 1
`define NWB_STAT_LOW_LSB 4

// AXI response codes.
`define NWB_RESP_OKAY 2'h0
`define NWB_RESP_DECERR 2'h3

`endif

// ==== include/nwb_pkg.sv ====
package nwb_pkg;

  // Cycle type held between edges; a continue repeats the current type.
  typedef enum logic [2:0] {
    ST_DESEL = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } nwb_state_t;

  // One word is four lanes of nine bits: parity on top of each byte.
  typedef logic [17:0] nwb_addr_t;
  typedef logic [35:0] nwb_word_t;
  typedef logic [3:0] nwb_be_t;

endpackage

// ==== include/nwb_mem_if.sv ====
`timescale 1ns/10ps

// Array access between the port pipeline and the storage module.
interface nwb_mem_if
  import nwb_pkg::*;
();
  logic ce;
  nwb_addr_t raddr;
  nwb_word_t rdata;
  logic we;
  nwb_addr_t waddr;
  nwb_be_t be;
  nwb_word_t wdata;

  modport port_side (output ce, output raddr, input rdata, output we, output waddr,
    output be, output wdata);
  modport mem_side (input ce, input raddr, output rdata, input we, input waddr,
    input be, input wdata);
endinterface

// ==== hw/nwb_mem.sv ====
`timescale 1ns/10ps

module nwb_mem
  import nwb_pkg::*;
(
  // Clock.
  input wire logic i_core_clk,
  // Array access.
  nwb_mem_if.mem_side mem
);

  localparam int DEPTH = 2 ** $bits(nwb_addr_t);

  // Each lane has its own array so that a write touches only its enabled bytes.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [8:0] lane_q [0:DEPTH-1];
    logic [8:0] rd_lane_q;

    // Read is write-first: a read of the word being written sees the new byte,
    // which spares the pipeline a separate forwarding path.
    always_ff @(posedge i_core_clk) begin
      if (mem.ce) begin
        if (mem.we && mem.be[g]) begin
          lane_q[mem.waddr] <= mem.wdata[9*g +: 9];
        end
        if (mem.we && mem.be[g] && (mem.waddr == mem.raddr)) begin
          rd_lane_q <= mem.wdata[9*g +: 9];
        end else begin
          rd_lane_q <= lane_q[mem.raddr];
        end
      end
    end

    assign mem.rdata[9*g +: 9] = rd_lane_q;
  end

endmodule // nwb_mem

// ==== hw/nwb_sram_port.sv ====
// Summary of operation
// - Advance low loads the address; advance high continues at the next burst address.
// - Load deselects unless all three selects are active; continue-deselect follows a deselect.
// - Selected load: read/write low writes, high reads; byte enables ignored on reads.
// - Writes update only lanes whose byte enable is low; all high aborts.
// - Read drives data only with output enable low; otherwise a dummy read.
// - Sleep high floats all data and parity lanes regardless of output enable.
// - Deselected or writing, the device never drives the data lanes.
// - Interleaved order steps the low bits as start XOR 01, 10, 11.
// - Data drivers stay off from reset until an enabled read drives them.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "nwb_defines.svh"

module nwb_sram_port
  import nwb_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // Synchronous memory controls.
  input wire logic [15:0] i_addr_high,
  input wire logic [1:0] i_burst_low_bits,
  input wire logic i_burst_step_or_load,
  input wire logic i_read_not_write,
  input wire logic [3:0] i_byte_write_n,
  input wire logic i_select_low_a_n,
  input wire logic i_select_high_b,
  input wire logic i_select_low_c_n,
  // Asynchronous controls.
  input wire logic i_out_en_n,
  input wire logic i_sleep_request,
  // Data and parity lanes.
  input wire logic [31:0] i_data_lanes,
  output logic [31:0] o_data_lanes,
  output logic o_data_lanes_oe,
  input wire logic [3:0] i_parity_lanes,
  output logic [3:0] o_parity_lanes,
  output logic o_parity_lanes_oe,
  // AXI4-Lite write channels.
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read channels.
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [31:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp
);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  nwb_mem_if mem ();

  nwb_state_t state_q, state_d;
  logic [15:0] high_q;
  logic [1:0] start_q, step_q, step_d, low_d;
  logic sel, load, rd_now, wr_now, ctrl_interleave_q;
  logic s1_rd_q, s1_wr_q, s2_rd_q, s2_wr_q, rd_drive_q;
  nwb_be_t s1_be_q, s2_be_q;
  nwb_addr_t s1_addr_q, s2_addr_q;
  nwb_word_t out_q, pin_word;
  logic aw_hold_q, w_hold_q, w_bit_q, bvalid_q, rvalid_q;
  logic [31:0] aw_addr_q, rdata_q, stat_word;
  logic [1:0] bresp_q, rresp_q;

  nwb_mem u_mem (
    .i_core_clk(i_core_clk),
    .mem(mem.mem_side)
  );

  // Cycle decode for the current edge.
  assign sel = !i_select_low_a_n && i_select_high_b && !i_select_low_c_n;
  assign load = !i_burst_step_or_load;
  assign rd_now = (state_d == ST_READ);
  assign wr_now = (state_d == ST_WRITE) && !(&i_byte_write_n);

  // Next cycle type and burst address. A continue keeps the current type, so a
  // continue-deselect is only reachable from a deselect.
  always_comb begin
    step_d = step_q + 2'h1;
    low_d = ctrl_interleave_q ? (start_q ^ step_d) : (start_q + step_d);
    case (state_q)
      ST_DESEL: state_d = ST_DESEL;
      ST_READ: state_d = ST_READ;
      ST_WRITE: state_d = ST_WRITE;
      default: state_d = ST_DESEL;
    endcase
    if (load) begin
      step_d = 2'h0;
      low_d = i_burst_low_bits;
      if (!sel) begin
        state_d = ST_DESEL;
      end else if (i_read_not_write) begin
        state_d = ST_READ;
      end else begin
        state_d = ST_WRITE;
      end
    end
  end

  // Burst counter and cycle state; only reset moves them while the clock enable is low.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= ST_DESEL;
      high_q <= 16'h0000;
      start_q <= 2'h0;
      step_q <= 2'h0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      step_q <= step_d;
      if (load) begin
        high_q <= i_addr_high;
        start_q <= i_burst_low_bits;
      end
    end
  end

  // Two-stage pipeline: stage one reads the array, stage two lines up with the
  // write data, and the output register lines up with the read data.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s1_rd_q <= 1'h0;
      s1_wr_q <= 1'h0;
      s1_be_q <= 4'h0;
      s1_addr_q <= 18'h00000;
      s2_rd_q <= 1'h0;
      s2_wr_q <= 1'h0;
      s2_be_q <= 4'h0;
      s2_addr_q <= 18'h00000;
      rd_drive_q <= 1'h0;
    end else if (i_clk_en) begin
      s1_rd_q <= rd_now;
      s1_wr_q <= wr_now;
      s1_be_q <= ~i_byte_write_n;
      s1_addr_q <= {(load ? i_addr_high : high_q), low_d};
      s2_rd_q <= s1_rd_q;
      s2_wr_q <= s1_wr_q;
      s2_be_q <= s1_be_q;
      s2_addr_q <= s1_addr_q;
      rd_drive_q <= s2_rd_q;
    end
  end

  // Read data register; only the drive flag needs a reset.
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en) begin
      out_q <= mem.rdata;
    end
  end

  // Array hookup: write data is sampled two edges after its address.
  assign mem.ce = i_clk_en;
  assign mem.raddr = s1_addr_q;
  assign mem.we = s2_wr_q;
  assign mem.waddr = s2_addr_q;
  assign mem.be = s2_be_q;
  assign mem.wdata = pin_word;

  // Lane mapping between pins and nine-bit word lanes.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign pin_word[9*g +: 9] = {i_parity_lanes[g], i_data_lanes[8*g +: 8]};
    assign o_data_lanes[8*g +: 8] = out_q[9*g +: 8];
    assign o_parity_lanes[g] = out_q[9*g+8];
  end

  // Output enable and sleep act without the clock, as a pin buffer would.
  assign o_data_lanes_oe = rd_drive_q && !i_out_en_n && !i_sleep_request;
  assign o_parity_lanes_oe = o_data_lanes_oe;

  // Register port readies; a frozen clock enable also stalls the bus.
  assign o_axi_awready = i_clk_en && !aw_hold_q && !bvalid_q;
  assign o_axi_wready = i_clk_en && !w_hold_q && !bvalid_q;
  assign o_axi_arready = i_clk_en && !rvalid_q;
  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp = bresp_q;
  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rdata = rdata_q;
  assign o_axi_rresp = rresp_q;

  // Write address and data are caught in either order; the response follows both.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      aw_hold_q <= 1'h0;
      w_hold_q <= 1'h0;
      w_bit_q <= 1'h0;
      aw_addr_q <= 32'h0000_0000;
      bvalid_q <= 1'h0;
      bresp_q <= `NWB_RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_hold_q <= 1'h1;
        aw_addr_q <= {i_axi_awaddr[31:2], 2'h0};
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_hold_q <= 1'h1;
        w_bit_q <= i_axi_wstrb[0] ? i_axi_wdata[`NWB_CTRL_INTERLEAVE_BIT] : ctrl_interleave_q;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q <= 1'h0;
        w_hold_q <= 1'h0;
        bvalid_q <= 1'h1;
        bresp_q <= ((aw_addr_q == `NWB_CTRL_OFS) || (aw_addr_q == `NWB_STAT_OFS)) ?
          `NWB_RESP_OKAY : `NWB_RESP_DECERR;
      end else if (bvalid_q && i_axi_bready) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // Burst order control; the reset value stands for a pin left open.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_interleave_q <= `NWB_CTRL_INTERLEAVE_RST;
    end else if (i_clk_en && aw_hold_q && w_hold_q && (aw_addr_q == `NWB_CTRL_OFS)) begin
      ctrl_interleave_q <= w_bit_q;
    end
  end

  // Status view of the port's own state.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`NWB_STAT_SLEEP_BIT] = i_sleep_request;
    stat_word[`NWB_STAT_STATE_LSB +: 3] = state_q;
    stat_word[`NWB_STAT_LOW_LSB +: 2] = s1_addr_q[1:0];
  end

  // Register reads answer at the same edge that takes the address.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `NWB_RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_axi_arvalid && o_axi_arready) begin
        rvalid_q <= 1'h1;
        rresp_q <= `NWB_RESP_OKAY;
        if ({i_axi_araddr[31:2], 2'h0} == `NWB_CTRL_OFS) begin
          rdata_q <= {31'h0000_0000, ctrl_interleave_q};
        end else if ({i_axi_araddr[31:2], 2'h0} == `NWB_STAT_OFS) begin
          rdata_q <= stat_word;
        end else begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `NWB_RESP_DECERR;
        end
      end else if (rvalid_q && i_axi_rready) begin
        rvalid_q <= 1'h0;
      end
    end
  end

  // Checks on the port pipeline.
  load_addr_a: assert property (i_clk_en && load && sel |=>
    s1_addr_q == $past({i_addr_high, i_burst_low_bits})) else $error("load address lost");
  desel_load_a: assert property (i_clk_en && load && !sel |=>
    state_q == ST_DESEL && !s1_rd_q && !s1_wr_q) else $error("deselect not taken");
  read_type_a: assert property (i_clk_en && load && sel && i_read_not_write |=>
    s1_rd_q && !s1_wr_q) else $error("read not decoded");
  abort_mask_a: assert property (mem.we |-> mem.be != 4'h0 && s2_wr_q)
    else $error("write with no lane");
  oe_gate_a: assert property (i_out_en_n || i_sleep_request |->
    !o_data_lanes_oe && !o_parity_lanes_oe) else $error("bus driven while disabled");
  write_float_a: assert property (i_clk_en && !rd_now ##1 i_clk_en ##1 i_clk_en |=>
    !rd_drive_q) else $error("non-read slot drives");
  reset_float_a: assert property ($past(i_srst) |-> !o_data_lanes_oe)
    else $error("driven after reset");
  interleave_a: assert property (i_clk_en && !load && ctrl_interleave_q |=>
    s1_addr_q[1:0] == ($past(start_q) ^ ($past(step_q) + 2'h1))) else $error("burst order wrong");
  hold_state_a: assert property (!i_clk_en |=> $stable(state_q) && $stable(s1_addr_q) &&
    $stable(step_q) && $stable(rd_drive_q)) else $error("state moved on hold");
  read_latency_a: assert property (i_clk_en && rd_now ##1 i_clk_en ##1 i_clk_en |=>
    rd_drive_q) else $error("read data slot late");

endmodule // nwb_sram_port

// ==== testbench/nwb_ctrl_model.sv ====
`timescale 1ns/10ps
// Controller model: one cycle per clock edge, enabled or not; write data two enabled edges later.
module nwb_ctrl_model
  import nwb_pkg::*;
(
  // Clock, clock enable and output-enable request.
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_oen_req,
  // Synchronous controls and write data.
  output nwb_addr_t o_addr = '0,
  output logic o_adv = 1'b0,
  output logic o_rnw = 1'b1,
  output nwb_be_t o_bwn = 4'hf,
  output logic [2:0] o_sel = 3'b110,
  output logic o_oen,
  output nwb_word_t o_wd = '0
);
  logic [36:0] w0_q = '0;
  logic [36:0] w1_q = '0;
  logic drv_q = 1'b0;

  // The whole address goes out, so the low bits seed the burst counter.
  task cyc(input logic [2:0] s, input logic ad, input logic rn, input nwb_be_t be,
    input nwb_addr_t a, input nwb_word_t wd, input logic wr);
    @(posedge i_clk);
    o_sel <= s;
    o_adv <= ad;
    o_rnw <= rn;
    o_bwn <= be;
    o_addr <= a;
    w0_q <= {wr, wd};
  endtask

  // Released lines flip on each enabled edge so stale data never passes for a read.
  always @(posedge i_clk) begin
    if (i_en) begin
      w1_q <= w0_q;
      drv_q <= w1_q[36];
      o_wd <= w1_q[36] ? w1_q[35:0] : ~o_wd;
    end
  end

  // Output enable is taken away while write data is on the bus.
  assign o_oen = i_oen_req | drv_q;
endmodule // nwb_ctrl_model

// ==== testbench/nwb_sram_port_tb_top.sv ====
`timescale 1ns/10ps
`include "nwb_defines.svh"
// Bench: a shadow pipe predicts every bus cycle from the issued operations.
module nwb_sram_port_tb_top
  import nwb_pkg::*;
;
  localparam logic [2:0] SEL = 3'b010;
  localparam logic [2:0] DS [3] = '{3'b110, 3'b000, 3'b011};
  localparam nwb_addr_t A = 18'h00104;
  localparam nwb_addr_t B = 18'h02a30;
  localparam nwb_word_t W1 = 36'hf_0123_4567;
  localparam nwb_word_t W2 = 36'h0_89ab_cdef;
  localparam nwb_word_t W3 = 36'h6_5a5a_a5a5;
  localparam nwb_word_t M = 36'hd_0123_cd67;
  localparam nwb_word_t DV [4] = '{36'h3_1111_1111, 36'hc_2222_2222, 36'h5_3333_3333,
    36'ha_4444_4444};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b1;
  logic oen_req = 1'b0;
  logic slp = 1'b0;
  int fails = 0;
  int tests_run = 0;
  logic [36:0] e0 = '0, e1 = '0, e2 = '0, e3 = '0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0] awa = '0, wd = '0, ara = '0, v;
  logic awr, wr, bv, arr, rv, doe, poe, m_adv, m_rnw, m_oen;
  logic [1:0] br, rr;
  logic [31:0] rd, od;
  logic [3:0] opar;
  logic [2:0] m_sel;
  nwb_addr_t m_addr;
  nwb_be_t m_bwn;
  nwb_word_t m_wd;

  always #2 clk = ~clk;

  nwb_ctrl_model u_m (.i_clk(clk), .i_en(en), .i_oen_req(oen_req), .o_addr(m_addr),
    .o_adv(m_adv), .o_rnw(m_rnw), .o_bwn(m_bwn), .o_sel(m_sel), .o_oen(m_oen), .o_wd(m_wd));

  // The shared lanes carry the port's data while its drive enable is up, the model's lines otherwise.
  nwb_sram_port u_dut (.i_core_clk(clk), .i_srst(srst), .i_clk_en(en),
    .i_addr_high(m_addr[17:2]), .i_burst_low_bits(m_addr[1:0]),
    .i_burst_step_or_load(m_adv), .i_read_not_write(m_rnw), .i_byte_write_n(m_bwn),
    .i_select_low_a_n(m_sel[2]), .i_select_high_b(m_sel[1]), .i_select_low_c_n(m_sel[0]),
    .i_out_en_n(m_oen), .i_sleep_request(slp), .i_data_lanes(doe ? od : m_wd[31:0]),
    .o_data_lanes(od), .o_data_lanes_oe(doe), .i_parity_lanes(poe ? opar : m_wd[35:32]),
    .o_parity_lanes(opar), .o_parity_lanes_oe(poe), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wr),
    .i_axi_wdata(wd), .i_axi_wstrb(4'hf), .o_axi_bvalid(bv), .i_axi_bready(bry),
    .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
    .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rd), .o_axi_rresp(rr));

  task cmp(input string n, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task end_of_test();
    $display("mismatches %0d comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task op(input logic [2:0] s, input logic ad, input logic rn, input nwb_be_t be,
    input nwb_addr_t a, input nwb_word_t w, input logic wrt, input logic rs, input nwb_word_t ex);
    u_m.cyc(s, ad, rn, be, a, w, wrt);
    e0 <= {rs, ex};
  endtask

  task idle(input int n);
    repeat (n) op(3'b110, 1'b0, 1'b1, 4'hf, '0, '0, 1'b0, 1'b0, '0);
  endtask

  // Each channel is released at the edge after its ready was seen high.
  task axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] g;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(negedge clk);
      ta = (awr === 1'b1) & awv;
      tw = (wr === 1'b1) & wv;
      tb = (bv === 1'b1);
      g = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bry <= 1'b0;
    cmp("bresp", 36'(er), 36'(g));
  endtask

  task axr(input logic [31:0] a, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] g;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(negedge clk);
      ta = (arr === 1'b1) & arv;
      tr = (rv === 1'b1);
      g = rr;
      v = rd;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rry <= 1'b0;
    cmp("rresp", 36'(er), 36'(g));
  endtask

  // The expectation moves only on enabled edges, as the port does.
  always @(posedge clk) begin
    if (en) begin
      e1 <= e0;
      e2 <= e1;
      e3 <= e2;
    end
  end

  // Bus drive is judged in the middle of every cycle, read data only in cycles where a driven read is expected.
  always @(negedge clk) begin
    cmp("drive", 36'({2{e3[36] & !m_oen & !slp}}), 36'({doe, poe}));
    if (e3[36] & !m_oen & !slp) cmp("rdata", e3[35:0], {opar, od});
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    op(SEL, 0, 0, 4'h0, A, W1, 1, 0, '0);
    op(SEL, 0, 0, 4'hd, A, W2, 1, 0, '0);
    op(SEL, 0, 0, 4'hf, A, W3, 1, 0, '0);
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, M);
    idle(1);
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, M);
    op(SEL, 0, 0, 4'h0, A, W3, 1, 0, '0);
    for (int k = 0; k < 4; k++) op(SEL, k != 0, 0, 4'h0, B | 18'h2, DV[k], 1, 0, '0);
    for (int j = 0; j < 4; j++) op(SEL, 0, 1, 4'h0, B | 18'(j), '0, 0, 1, DV[j ^ 2]);
    for (int k = 0; k < 4; k++) op(SEL, k != 0, 1, 4'h0, B | 18'h1, '0, 0, 1, DV[k ^ 3]);
    foreach (DS[i]) op(DS[i], 0, 1, 4'h0, A, '0, 0, 0, '0);
    foreach (DS[i]) op(DS[i], 1, 0, 4'h0, A, '0, 0, 0, '0);
    idle(2);
    oen_req <= 1'b1;
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, W3);
    idle(3);
    oen_req <= 1'b0;
    slp <= 1'b1;
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, W3);
    idle(3);
    slp <= 1'b0;
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, W3);
    idle(1);
    @(posedge clk) en <= 1'b0;
    u_m.cyc(SEL, 1'b0, 1'b0, 4'h0, A, W1, 1'b0);
    u_m.cyc(3'b110, 1'b0, 1'b1, 4'hf, '0, '0, 1'b0);
    @(posedge clk) en <= 1'b1;
    op(SEL, 0, 1, 4'h0, A, '0, 0, 1, W3);
    idle(3);
    axr(`NWB_CTRL_OFS, `NWB_RESP_OKAY);
    cmp("ctrl", 36'h1, 36'(v));
    axr(`NWB_STAT_OFS, `NWB_RESP_OKAY);
    cmp("status", 36'h2, 36'(v[3:0]));
    axw(32'h8, 32'h0, `NWB_RESP_DECERR);
    axr(32'h8, `NWB_RESP_DECERR);
    cmp("unmapped", 36'h0, 36'(v));
    axw(`NWB_CTRL_OFS, 32'h0, `NWB_RESP_OKAY);
    // Linear order after the control bit is cleared: start plus step.
    for (int k = 0; k < 4; k++) begin
      op(SEL, k != 0, 1, 4'h0, B | 18'h1, '0, 0, 1, DV[((1 + k) & 3) ^ 2]);
    end
    idle(3);
    end_of_test();
  end
endmodule // nwb_sram_port_tb_top
